// >>> rtl/fsd_top.sv
// Notes on behaviour
// - unsecured when security state bits are 10 or after a passed special single-chip blank check
// - backdoor enabled only when backdoor enable bits are 10
// - option byte at ff0f: enable 7:6, spare 5:2, security 1:0
// - every reset copies the option byte into the shadow register
// - option byte also readable at bf0f with page 3f selected
// - secured normal single-chip blocks the background debug unit
// - secured normal single-chip restricts flash and eeprom commands
// - secured normal single-chip stops trace capture
// - secured debug hardware commands reach only peripheral registers
// - backdoor key at ff00-ff07, valid value and enable needed
// - secured special single-chip, blank check fail: hardware commands only
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsd_params.svh"
module fsd_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash read port
	output fsd_pkg::fsd_addr_t flash_addr,
	output logic flash_req,
	input wire logic flash_ack,
	input wire logic [15:0] flash_rdata,
	// cpu view of flash page window
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] program_page_select,
	output logic cpu_opt_hit,
	// mode inputs
	input wire logic normal_single_chip,
	input wire logic special_single_chip,
	input wire logic blank_check_pass,
	input wire logic blank_check_done,
	// debug hardware command address
	input wire logic [15:0] hwcmd_addr,
	// decoded state
	output logic secured,
	output logic backdoor_en,
	output logic shadow_valid,
	output logic debug_block,
	output logic debug_fw_enable,
	output logic debug_hw_enable,
	output logic hwcmd_addr_ok,
	output logic nvm_restrict,
	output logic trace_disable
);
	import fsd_pkg::*;

	// ----------------------------------------
	// reset-time shadow load
	// ----------------------------------------
	fsd_state_t st_r, st_nxt;
	logic [7:0] shadow_r, shadow_nxt;
	logic [2:0] kidx_r, kidx_nxt;
	logic [3:0] kok_r, kok_nxt;
	logic unsec_r, unsec_nxt;
	// key words kept so each one is checked by its own comparator
	logic [15:0] key_mem [0:3];
	logic [15:0] key_mem_nxt [0:3];
	logic [3:0] key_word_ok;
	logic [3:0] key_good;
	logic dec_secured, dec_backdoor;

	// ----------------------------------------
	// per-word key validity
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_key
			fsd_key_check u_key (
				.word(key_mem[g]),
				.word_ok(key_word_ok[g])
			);
		end
	endgenerate

	// a word counts only once it has really been fetched
	assign key_good = kok_r & key_word_ok;

	fsd_decode u_dec (
		.opt_byte(shadow_r),
		.secured(dec_secured),
		.backdoor_en(dec_backdoor)
	);

	always_comb begin
		st_nxt = st_r;
		shadow_nxt = shadow_r;
		kidx_nxt = kidx_r;
		kok_nxt = kok_r;
		key_mem_nxt = key_mem;
		flash_req = 1'b0;
		flash_addr = `FSD_OPT_ADDR;
		case (st_r)
			FSD_IDLE: begin
				st_nxt = FSD_REQ_OPT;
			end
			FSD_REQ_OPT: begin
				flash_req = 1'b1;
				flash_addr = `FSD_OPT_ADDR;
				if (flash_ack) begin
					shadow_nxt = flash_rdata[7:0];
					st_nxt = FSD_REQ_KEY;
				end
			end
			FSD_REQ_KEY: begin
				flash_req = 1'b1;
				flash_addr = `FSD_KEY_BASE + {12'h000, kidx_r[1:0], 1'b0, 1'b0} / 16'h0002;
				if (flash_ack) begin
					kok_nxt[kidx_r[1:0]] = 1'b1;
					key_mem_nxt[kidx_r[1:0]] = flash_rdata;
					kidx_nxt = kidx_r + 3'h1;
					if (kidx_r == (`FSD_KEY_WORDS - 3'h1)) begin
						st_nxt = FSD_DONE;
					end
				end
			end
			FSD_DONE: begin
				st_nxt = FSD_DONE;
			end
			default: begin
				st_nxt = FSD_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= FSD_IDLE;
			shadow_r <= `FSD_OPT_RESET;
			kidx_r <= 3'h0;
			kok_r <= 4'h0;
			for (int j = 0; j < 4; j++) begin
				key_mem[j] <= 16'h0000;
			end
		end else begin
			st_r <= st_nxt;
			shadow_r <= shadow_nxt;
			kidx_r <= kidx_nxt;
			kok_r <= kok_nxt;
			key_mem <= key_mem_nxt;
		end
	end

	// ----------------------------------------
	// security outputs
	// ----------------------------------------
	logic lock_eff;
	logic in_preg;

	// secured by default until the shadow and all four key words are loaded, so nothing leaks early
	assign shadow_valid = (st_r == FSD_DONE);
	assign lock_eff = !shadow_valid || (dec_secured && !unsec_r);
	assign secured = lock_eff;
	assign backdoor_en = shadow_valid && dec_backdoor && (&key_good);

	assign debug_block = lock_eff && normal_single_chip;
	assign nvm_restrict = lock_eff && (normal_single_chip || special_single_chip);
	assign trace_disable = lock_eff && (normal_single_chip || special_single_chip);
	assign debug_fw_enable = !lock_eff && !normal_single_chip;
	// blocked while the blank check runs
	assign debug_hw_enable = !debug_block &&
		!(lock_eff && special_single_chip && !blank_check_done);
	assign in_preg = (hwcmd_addr >= `FSD_PREG_LO) && (hwcmd_addr <= `FSD_PREG_HI);
	assign hwcmd_addr_ok = !lock_eff || in_preg;

	assign cpu_opt_hit = (cpu_addr == `FSD_OPT_ADDR) ||
		((cpu_addr == `FSD_OPT_PAGED_ADDR) && (program_page_select == `FSD_OPT_PAGE));

	// ----------------------------------------
	// temporary unsecure after blank check
	// ----------------------------------------
	// passing blank check in special mode lifts security until next reset
	always_comb begin
		unsec_nxt = unsec_r;
		if (shadow_valid && special_single_chip && blank_check_done && blank_check_pass) begin
			unsec_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unsec_r <= 1'b0;
		end else begin
			unsec_r <= unsec_nxt;
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic setup;

	assign setup = psel && !penable;
	assign pready = psel && penable;
	assign prdata = rdata_r;
	assign pslverr = pready && err_r;

	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (setup) begin
			err_nxt = 1'b0;
			rdata_nxt = 32'h0000_0000;
			case (paddr)
				`FSD_REG_OPT: begin
					rdata_nxt = {24'h000000, shadow_r};
				end
				`FSD_REG_STATUS: begin
					rdata_nxt = {25'h0000000, unsec_r, debug_block, trace_disable,
						nvm_restrict, shadow_valid, backdoor_en, secured};
				end
				`FSD_REG_KEY: begin
					rdata_nxt = {28'h0000000, key_good};
				end
				default: begin
					err_nxt = 1'b1;
				end
			endcase
			// registers are read only
			if (pwrite) begin
				err_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	logic unused_w;
	assign unused_w = ^pwdata;
endmodule : fsd_top
`default_nettype wire

// >>> rtl/fsd_params.svh
`ifndef FSD_PARAMS_SVH
`define FSD_PARAMS_SVH

// flash addresses of the option byte and backdoor key
`define FSD_OPT_ADDR 16'hff0f
`define FSD_OPT_PAGED_ADDR 16'hbf0f
`define FSD_OPT_PAGE 8'h3f
`define FSD_KEY_BASE 16'hff00
`define FSD_KEY_WORDS 3'h4

// option byte fields
`define FSD_BKEN_HI 7
`define FSD_BKEN_LO 6
`define FSD_SST_HI 1
`define FSD_SST_LO 0
`define FSD_SST_UNSECURED 2'h2
`define FSD_BKEN_ENABLED 2'h2
`define FSD_SST_RECOMMENDED 2'h1

// apb register map (byte addresses)
`define FSD_REG_OPT 12'hf0f
`define FSD_REG_STATUS 12'h000
`define FSD_REG_KEY 12'h004
`define FSD_REG_CTRL 12'h008
`define FSD_OPT_RESET 8'hff
`define FSD_PREG_LO 16'h0000
`define FSD_PREG_HI 16'h03ff

`endif

// >>> rtl/fsd_pkg.sv
package fsd_pkg;
	typedef enum logic [2:0] {
		FSD_IDLE = 3'h0,
		FSD_REQ_OPT = 3'h1,
		FSD_REQ_KEY = 3'h3,
		FSD_DONE = 3'h2
	} fsd_state_t;
	typedef logic [15:0] fsd_addr_t;
endpackage : fsd_pkg

// >>> rtl/fsd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsd_params.svh"
module fsd_decode (
	// shadow byte
	input wire logic [7:0] opt_byte,
	// decoded
	output logic secured,
	output logic backdoor_en
);
	always_comb begin
		secured = (opt_byte[`FSD_SST_HI:`FSD_SST_LO] != `FSD_SST_UNSECURED);
		backdoor_en = (opt_byte[`FSD_BKEN_HI:`FSD_BKEN_LO] == `FSD_BKEN_ENABLED);
	end
endmodule : fsd_decode
`default_nettype wire

// >>> rtl/fsd_key_check.sv
`timescale 1ns/1ps
`default_nettype none
module fsd_key_check (
	// key word
	input wire logic [15:0] word,
	// result
	output logic word_ok
);
	// erased or zero words are never a valid key
	always_comb begin
		word_ok = (word != 16'h0000) && (word != 16'hffff);
	end
endmodule : fsd_key_check
`default_nettype wire

// >>> tb/fsd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module fsd_top_props (
	// watched ports
	input wire logic pclk, presetn, flash_req, cpu_opt_hit,
	input wire fsd_pkg::fsd_addr_t flash_addr,
	input wire logic [15:0] cpu_addr, hwcmd_addr,
	input wire logic [7:0] program_page_select,
	input wire logic normal_single_chip, special_single_chip,
	input wire logic secured, backdoor_en, shadow_valid, debug_block,
	input wire logic hwcmd_addr_ok, nvm_restrict, trace_disable
);
	import fsd_pkg::*;
	logic sc_s;
	assign sc_s = secured & (normal_single_chip | special_single_chip);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_early_lock: assert property (!shadow_valid |-> secured && !backdoor_en)
		else $error("open before load");
	chk_load_first: assert property ($rose(flash_req) |-> flash_addr == 16'hff0f)
		else $error("first fetch address");
	chk_hold_key: assert property (shadow_valid |=> shadow_valid && $stable(backdoor_en))
		else $error("decoded state moved");
	chk_debug_gate: assert property (debug_block == (secured && normal_single_chip))
		else $error("debug gate");
	chk_nvm_limit: assert property (nvm_restrict == sc_s)
		else $error("nvm limit");
	chk_trace_off: assert property (trace_disable == sc_s)
		else $error("trace gate");
	chk_hwcmd_space: assert property (hwcmd_addr_ok == (!secured || hwcmd_addr <= 16'h03ff))
		else $error("debug space");
	chk_page_alias: assert property (cpu_opt_hit == (cpu_addr == 16'hff0f ||
		(cpu_addr == 16'hbf0f && program_page_select == 8'h3f)))
		else $error("alias hit");
	cover property (shadow_valid && !secured);
	cover property (shadow_valid && backdoor_en);
	cover property (debug_block);
endmodule : fsd_top_props
bind fsd_top fsd_top_props u_props (.*);
`default_nettype wire

// >>> tb/fsd_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsd_flash_model (
	// clock, request
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flash_req,
	input wire fsd_pkg::fsd_addr_t flash_addr,
	// stored contents
	input wire logic [7:0] opt_val,
	input wire logic [15:0] key_val,
	// answer
	output logic flash_ack,
	output logic [15:0] flash_rdata
);
	import fsd_pkg::*;
	logic ack_nxt;
	logic [15:0] dat_nxt;
	// option at ff0f, key words below
	always_comb begin
		ack_nxt = flash_req & ~flash_ack;
		dat_nxt = ~flash_rdata;
		if (ack_nxt)
			dat_nxt = (flash_addr == 16'hff0f) ? {8'h00, opt_val} : key_val;
	end
	// data toggles when idle so stale values never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_ack <= 1'b0;
			flash_rdata <= 16'h0000;
		end else begin
			flash_ack <= ack_nxt;
			flash_rdata <= dat_nxt;
		end
	end
endmodule : fsd_flash_model
`default_nettype wire

// >>> tb/tb_flash_security_state_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_security_state_decoder;
	import fsd_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, d;
	logic pready, pslverr, se, flash_req, flash_ack, cpu_opt_hit;
	fsd_addr_t flash_addr;
	logic [15:0] flash_rdata, key_val = 16'h1234, cpu_addr = 16'h0000, hwcmd_addr = 16'h0000;
	logic [7:0] program_page_select = 8'h00, opt_val = 8'hff;
	logic normal_single_chip = 1'b1, special_single_chip = 1'b0;
	logic blank_check_pass = 1'b0, blank_check_done = 1'b0;
	logic secured, backdoor_en, shadow_valid, debug_block, debug_fw_enable, debug_hw_enable;
	logic hwcmd_addr_ok, nvm_restrict, trace_disable;
	int err_total = 0, n_checks = 0, i;
	always #4 pclk = ~pclk;
	fsd_top DUT (.*);
	fsd_flash_model u_flash (.pclk(pclk), .presetn(presetn), .flash_req(flash_req),
		.flash_addr(flash_addr), .opt_val(opt_val), .key_val(key_val),
		.flash_ack(flash_ack), .flash_rdata(flash_rdata));
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'h0000_00a5;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int k = 0; pready !== 1'b1; k++) begin
			if (k == 20) begin
				err_total++;
				end_sim();
			end
			@(posedge pclk);
		end
		d = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// shadow load happens at every reset release
	task boot(input logic [7:0] o, input logic [15:0] k, input int n);
		presetn <= 1'b0;
		opt_val <= o;
		key_val <= k;
		repeat (n) @(posedge pclk);
		presetn <= 1'b1;
		for (int c = 0; shadow_valid !== 1'b1; c++) begin
			if (c == 100) begin
				err_total++;
				end_sim();
			end
			@(posedge pclk);
		end
	endtask : boot
	initial begin
		boot(8'hff, 16'h1234, 20);
		for (i = 0; i < 16; i++) begin
			boot({i[3:2], 4'ha, i[1:0]}, 16'h1234, 2);
			chk(secured, i[1:0] != 2'b10);
			chk(backdoor_en, i[3:2] == 2'b10);
			apb(1'b0, 12'hf0f);
			chk(d, {24'h0, i[3:2], 4'ha, i[1:0]});
		end
		for (i = 0; i < 2; i++) begin
			boot(8'h82, i ? 16'hffff : 16'h0000, 2);
			chk(backdoor_en, 1'b0);
		end
		opt_val <= 8'h01;
		repeat (10) @(posedge pclk);
		chk(secured, 1'b0);
		apb(1'b1, 12'hf0f);
		chk(se, 1'b1);
		apb(1'b0, 12'h100);
		chk(se, 1'b1);
		boot(8'h01, 16'h1234, 2);
		hwcmd_addr <= 16'h0400;
		@(posedge pclk);
		chk({debug_block, nvm_restrict, trace_disable, hwcmd_addr_ok}, 4'he);
		normal_single_chip <= 1'b0;
		special_single_chip <= 1'b1;
		hwcmd_addr <= 16'h03ff;
		@(posedge pclk);
		chk({debug_block, debug_fw_enable, debug_hw_enable, hwcmd_addr_ok}, 4'h1);
		blank_check_done <= 1'b1;
		@(posedge pclk);
		chk({secured, debug_hw_enable, debug_fw_enable}, 3'h6);
		blank_check_pass <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({secured, debug_fw_enable}, 2'h1);
		for (i = 0; i < 4; i++) begin
			cpu_addr <= i[1] ? 16'hbf0f : 16'hff0f - i[0];
			program_page_select <= i[0] ? 8'h3e : 8'h3f;
			@(posedge pclk);
			chk(cpu_opt_hit, i[0] == 1'b0);
		end
		end_sim();
	end
endmodule : tb_flash_security_state_decoder
`default_nettype wire
